//--- common/sfe_pkg.sv
// ---------------------------------------------------------------
// shared constants of the serial flash front end
// ---------------------------------------------------------------
package sfe_pkg;

   // lane widths of a transfer
   typedef enum logic [1:0] {
      LANE_SINGLE,
      LANE_DUAL,
      LANE_QUAD
   } sfe_lane_t;

   // ---------------------------------------------------------------
   // data and address widths
   // ---------------------------------------------------------------
   localparam int BYTE_W = 8;
   localparam int CNT_W = 4;
   localparam int ADDR_W = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_BYTE = 4'h8;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
   localparam logic [CNT_W-1:0] CNT_FOUR = 4'h4;

   // ---------------------------------------------------------------
   // array map: 4 KB sectors, 32 KB half blocks, 64 KB blocks
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] TOP_ADDR = 24'h1fffff;
   localparam int SECTOR_LSB = 12;
   localparam int HALF_LSB = 15;
   localparam int BLOCK_LSB = 16;
   localparam int SECTOR_W = 9;
   localparam int HALF_W = 6;
   localparam int BLOCK_W = 5;

   // ---------------------------------------------------------------
   // reset values and the underrun fill byte
   // ---------------------------------------------------------------
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_IDLE = 8'hff;

   // number of bits moved per clock edge for a lane setting
   function automatic logic [CNT_W-1:0] lane_bits(input sfe_lane_t lane);
      lane_bits = (lane == LANE_QUAD) ? CNT_FOUR : ((lane == LANE_DUAL) ? CNT_TWO : CNT_ONE);
   endfunction : lane_bits

endpackage : sfe_pkg

//--- core/sfe_front_end.sv
`timescale 1ns/1ps
//
// Contract
// - single mode drives data line one after falls
// - dual/quad line one samples rise, drives fall
// - pin low, locks 0/1 refuse status writes
// - same lock refuses protected array program/erase
// - quad enable disables pin write protection
// - quad: line two samples rise, drives fall
// - pause pin: pause/reset, or data line three
// - pause suspends link, internal operations continue
// - pause entry only while serial clock low
// - pause exit only while serial clock low
// - 512 aligned 4 KB sectors up to top
// - 32 blocks of 64 KB, 64 halves
// - works with clock mode 0 or 3
// - dual reads move two bits per edge
// - quad needs quad enable set by host
// - inputs sampled rising, outputs shifted falling
// - no selection before first select falling edge; the pin drivers do not wait for it
// - power-on reset holds device, ignores instructions
// - deselected: ignore inputs, outputs high impedance
// - paused: output released, inputs don't care
// - deselect while paused resets interface state
// - reset select makes pause pin active-low reset
module sfe_front_end #(
   parameter int ADDR_W = sfe_pkg::ADDR_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic data_line_zero_in,
   output logic data_line_zero_out,
   output logic data_line_zero_oe_n,
   input wire logic data_line_one_in,
   output logic data_line_one_out,
   output logic data_line_one_oe_n,
   input wire logic data_line_two_in,
   output logic data_line_two_out,
   output logic data_line_two_oe_n,
   input wire logic data_line_three_in,
   output logic data_line_three_out,
   output logic data_line_three_oe_n,
   input wire logic status_lock_upper,
   input wire logic status_lock_lower,
   input wire logic quad_enable_bit,
   input wire logic pause_reset_select,
   input wire sfe_pkg::sfe_lane_t lane_mode,
   input wire logic drive_phase,
   output logic [sfe_pkg::BYTE_W-1:0] rx_data,
   output logic rx_valid,
   input wire logic [sfe_pkg::BYTE_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [ADDR_W-1:0] op_addr,
   input wire logic array_region_protected,
   output logic status_write_refused,
   output logic array_write_refused,
   output logic [sfe_pkg::SECTOR_W-1:0] sector_index,
   output logic [sfe_pkg::HALF_W-1:0] half_block_index,
   output logic [sfe_pkg::BLOCK_W-1:0] block_index,
   output logic addr_out_of_range,
   output logic link_selected,
   output logic link_paused,
   output logic pin_reset_active
);

   // ---------------------------------------------------------------
   // pin function selection
   // ---------------------------------------------------------------
   // the fourth pin is a pause or reset pin only while quad is off
   wire pause_fn = ~quad_enable_bit & ~pause_reset_select;
   wire reset_fn = ~quad_enable_bit & pause_reset_select;
   // reset function: low level on the pin resets the interface
   wire pin_reset = reset_fn & ~data_line_three_in;
   // link state clears on deselect, power-on reset or pin reset
   wire link_rst = chip_select_n | rst | pin_reset;
   // quad lanes only exist with quad enable set by the host
   wire quad_ok = quad_enable_bit & (lane_mode == sfe_pkg::LANE_QUAD);

   // ---------------------------------------------------------------
   // pause state
   // ---------------------------------------------------------------
   // transparent only while the serial clock is low, so a pin edge
   // seen with the clock high waits until the clock falls
   logic pause_lat; // paused, held stable over clock-high phase
   always_latch
   begin
      if (link_rst)
         pause_lat = 1'b0;
      else if (!serial_clk)
         pause_lat = pause_fn & ~data_line_three_in;
   end

   // ---------------------------------------------------------------
   // link side: configuration crossing into the serial clock domain
   // ---------------------------------------------------------------
   // drive phase is quasi-static; two stages on the link clock
   logic drv_s1_q, drv_s2_q; // synced drive phase
   always_ff @(posedge serial_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         drv_s1_q <= 1'b0;
         drv_s2_q <= 1'b0;
      end
      else
      begin
         drv_s1_q <= drive_phase;
         drv_s2_q <= drv_s1_q;
      end
   end

   // lane width in effect on the link; quad enable is static and must
   // hold from the first edge of a frame, so it is not staged
   wire sfe_pkg::sfe_lane_t link_lane = (lane_mode == sfe_pkg::LANE_QUAD && !quad_ok) ?
      sfe_pkg::LANE_DUAL : lane_mode;
   wire [sfe_pkg::CNT_W-1:0] step = sfe_pkg::lane_bits(link_lane);
   wire link_drive = drv_s2_q;

   // ---------------------------------------------------------------
   // link side: receive shifter, rising edge
   // ---------------------------------------------------------------
   // lines gathered msb first: three, two, one, zero
   wire [3:0] in_bits = (link_lane == sfe_pkg::LANE_QUAD) ?
      {data_line_three_in, data_line_two_in, data_line_one_in, data_line_zero_in} :
      ((link_lane == sfe_pkg::LANE_DUAL) ? {2'h0, data_line_one_in, data_line_zero_in} :
      {3'h0, data_line_zero_in});
   logic [sfe_pkg::BYTE_W-1:0] rx_sh_q, rx_sh_d; // partial byte
   logic [sfe_pkg::CNT_W-1:0] rx_cnt_q, rx_cnt_d; // bits gathered
   logic [sfe_pkg::BYTE_W-1:0] rx_byte_q; // last whole byte, held for crossing
   logic rx_tgl_q; // flips once per whole byte
   always_comb
   begin
      rx_sh_d = rx_sh_q;
      rx_cnt_d = rx_cnt_q + step;
      unique case (link_lane)
         sfe_pkg::LANE_QUAD: rx_sh_d = {rx_sh_q[sfe_pkg::BYTE_W-5:0], in_bits};
         sfe_pkg::LANE_DUAL: rx_sh_d = {rx_sh_q[sfe_pkg::BYTE_W-3:0], in_bits[1:0]};
         sfe_pkg::LANE_SINGLE: rx_sh_d = {rx_sh_q[sfe_pkg::BYTE_W-2:0], in_bits[0]};
      endcase
   end

   // inputs latched on rising edges, never while paused or driving
   always_ff @(posedge serial_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         // a partial byte is simply thrown away
         rx_sh_q <= sfe_pkg::BYTE_RST;
         rx_cnt_q <= sfe_pkg::CNT_ZERO;
      end
      else if (!pause_lat && !link_drive)
      begin
         rx_sh_q <= rx_sh_d;
         rx_cnt_q <= (rx_cnt_d == sfe_pkg::CNT_BYTE) ? sfe_pkg::CNT_ZERO : rx_cnt_d;
      end
   end

   // whole byte and its toggle survive deselect so the core can fetch it
   always_ff @(posedge serial_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_byte_q <= sfe_pkg::BYTE_RST;
         rx_tgl_q <= 1'b0;
      end
      else if (!link_rst && !pause_lat && !link_drive && rx_cnt_d == sfe_pkg::CNT_BYTE)
      begin
         rx_byte_q <= rx_sh_d;
         rx_tgl_q <= ~rx_tgl_q;
      end
   end

   // ---------------------------------------------------------------
   // link side: transmit shifter, falling edge
   // ---------------------------------------------------------------
   // a mode 3 host starts with a falling edge; the shifter only loads
   // in a drive phase, so that edge is harmless
   logic [1:0] req_s_q; // request toggle synchroniser, [1] usable
   logic req_tgl_q; // flips when a tx byte is handed over
   logic ack_tgl_q; // flips when a held byte is taken
   logic [sfe_pkg::BYTE_W-1:0] tx_hold_q; // byte from the core domain
   logic [sfe_pkg::BYTE_W-1:0] tx_sh_q; // remaining bits, msb first
   logic [sfe_pkg::CNT_W-1:0] tx_left_q; // bits still in the shifter
   logic [3:0] out_q; // bits on the pins
   wire tx_empty = (tx_left_q == sfe_pkg::CNT_ZERO);
   wire have_byte = (req_s_q[1] != ack_tgl_q);
   // an underrun shifts ones rather than stale data
   wire [sfe_pkg::BYTE_W-1:0] tx_src = tx_empty ? (have_byte ? tx_hold_q : sfe_pkg::BYTE_IDLE) : tx_sh_q;
   always_ff @(negedge serial_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         tx_sh_q <= sfe_pkg::BYTE_RST;
         tx_left_q <= sfe_pkg::CNT_ZERO;
         out_q <= 4'h0;
      end
      else
      begin
         if (link_drive && !pause_lat)
         begin
            // outputs change only after a falling edge
            out_q <= (link_lane == sfe_pkg::LANE_QUAD) ? tx_src[7:4] :
               ((link_lane == sfe_pkg::LANE_DUAL) ? {2'h0, tx_src[7:6]} : {3'h0, tx_src[7]});
            tx_sh_q <= tx_src << step;
            tx_left_q <= (tx_empty ? sfe_pkg::CNT_BYTE : tx_left_q) - step;
         end
      end
   end

   // request synchroniser and acknowledge toggle survive deselect, so a
   // stale request never looks new in the next frame
   always_ff @(negedge serial_clk or posedge rst)
   begin
      if (rst)
      begin
         req_s_q <= 2'h0;
         ack_tgl_q <= 1'b0;
      end
      else
      begin
         req_s_q <= {req_s_q[0], req_tgl_q};
         if (!link_rst && link_drive && !pause_lat && tx_empty && have_byte)
            ack_tgl_q <= ~ack_tgl_q;
      end
   end

   // ---------------------------------------------------------------
   // pin drivers
   // ---------------------------------------------------------------
   // enables are low while driving; any deselect or pause releases all
   wire drv_ok = ~link_rst & ~pause_lat & link_drive;
   assign data_line_one_out = (link_lane == sfe_pkg::LANE_SINGLE) ? out_q[0] : out_q[1];
   assign data_line_one_oe_n = ~drv_ok;
   assign data_line_zero_out = out_q[0];
   assign data_line_zero_oe_n = ~(drv_ok & (link_lane != sfe_pkg::LANE_SINGLE));
   assign data_line_two_out = out_q[2];
   assign data_line_two_oe_n = ~(drv_ok & (link_lane == sfe_pkg::LANE_QUAD));
   assign data_line_three_out = out_q[3];
   assign data_line_three_oe_n = ~(drv_ok & (link_lane == sfe_pkg::LANE_QUAD));

   // ---------------------------------------------------------------
   // core side: pin synchronisers
   // ---------------------------------------------------------------
   // bits: cs_n, protect pin, pause latch, pin reset, rx toggle, ack toggle
   logic [5:0] s1_q, s2_q; // first stage read only by the second
   logic rx_tgl_seen_q; // last rx toggle acted on
   logic cs_prev_q; // synced select one cycle ago
   always_ff @(posedge ref_clk)
   begin
      s1_q <= {chip_select_n, data_line_two_in, pause_lat, pin_reset, rx_tgl_q, ack_tgl_q};
      s2_q <= s1_q;
   end
   wire cs_n_s = s2_q[5];
   wire wp_s = s2_q[4];
   wire ack_s = s2_q[0];

   // ---------------------------------------------------------------
   // core side: power-up select gating
   // ---------------------------------------------------------------
   // armed once select was seen high after reset; a frame starts only on
   // a later falling edge, so a select stuck low at power-up raises neither rx_valid nor link_selected
   logic armed_q; // select has been high since reset
   logic frame_ok_q; // current frame began with a proper falling edge
   wire cs_fall = cs_prev_q & ~cs_n_s;
   always_ff @(posedge ref_clk)
   begin
      if (rst || s2_q[2])
      begin
         armed_q <= 1'b0;
         frame_ok_q <= 1'b0;
         cs_prev_q <= 1'b0;
      end
      else
      begin
         cs_prev_q <= cs_n_s;
         armed_q <= armed_q | cs_n_s;
         frame_ok_q <= cs_n_s ? 1'b0 : (frame_ok_q | (cs_fall & armed_q));
      end
   end

   // ---------------------------------------------------------------
   // core side: receive and transmit handshakes
   // ---------------------------------------------------------------
   logic [sfe_pkg::BYTE_W-1:0] rx_data_q; // delivered byte
   logic rx_valid_q; // one-cycle strobe
   wire rx_new = (s2_q[1] != rx_tgl_seen_q);
   assign tx_ready = (req_tgl_q == ack_s);
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rx_tgl_seen_q <= 1'b0;
         rx_data_q <= sfe_pkg::BYTE_RST;
         rx_valid_q <= 1'b0;
         req_tgl_q <= 1'b0;
         tx_hold_q <= sfe_pkg::BYTE_RST;
      end
      else
      begin
         rx_tgl_seen_q <= s2_q[1];
         // bytes outside a properly started frame are dropped
         rx_valid_q <= rx_new & frame_ok_q;
         if (rx_new)
            rx_data_q <= rx_byte_q;
         if (tx_valid && tx_ready)
         begin
            tx_hold_q <= tx_data;
            req_tgl_q <= ~req_tgl_q;
         end
      end
   end
   assign rx_data = rx_data_q;
   assign rx_valid = rx_valid_q;

   // ---------------------------------------------------------------
   // core side: write protection and array map
   // ---------------------------------------------------------------
   // hardware lock: pin low, upper lock 0, lower lock 1, quad off
   wire hw_lock = ~quad_enable_bit & ~wp_s & ~status_lock_upper & status_lock_lower;
   logic refuse_st_q, refuse_arr_q, range_q; // registered verdicts
   logic [sfe_pkg::SECTOR_W-1:0] sector_q;
   logic [sfe_pkg::HALF_W-1:0] half_q;
   logic [sfe_pkg::BLOCK_W-1:0] block_q;
   logic paused_q, pin_rst_q, sel_q; // status views
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         refuse_st_q <= 1'b0;
         refuse_arr_q <= 1'b0;
         range_q <= 1'b0;
         sector_q <= '0;
         half_q <= '0;
         block_q <= '0;
         paused_q <= 1'b0;
         pin_rst_q <= 1'b0;
         sel_q <= 1'b0;
      end
      else
      begin
         refuse_st_q <= hw_lock;
         refuse_arr_q <= hw_lock & array_region_protected;
         range_q <= (op_addr > sfe_pkg::TOP_ADDR);
         sector_q <= op_addr[sfe_pkg::SECTOR_LSB +: sfe_pkg::SECTOR_W];
         half_q <= op_addr[sfe_pkg::HALF_LSB +: sfe_pkg::HALF_W];
         block_q <= op_addr[sfe_pkg::BLOCK_LSB +: sfe_pkg::BLOCK_W];
         // pausing only touches the link; engines keep running
         paused_q <= s2_q[3];
         pin_rst_q <= s2_q[2];
         sel_q <= frame_ok_q;
      end
   end
   assign status_write_refused = refuse_st_q;
   assign array_write_refused = refuse_arr_q;
   assign addr_out_of_range = range_q;
   assign sector_index = sector_q;
   assign half_block_index = half_q;
   assign block_index = block_q;
   assign link_paused = paused_q;
   assign pin_reset_active = pin_rst_q;
   assign link_selected = sel_q;

endmodule : sfe_front_end

//--- bench/sfe_front_end_assertions.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker of the serial flash front end
// ---------------------------------------------------------------
module sfe_front_end_checker #(
   parameter int ADDR_W = sfe_pkg::ADDR_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic data_line_zero_oe_n,
   input wire logic data_line_one_oe_n,
   input wire logic data_line_two_in,
   input wire logic data_line_three_in,
   input wire logic status_lock_upper,
   input wire logic status_lock_lower,
   input wire logic quad_enable_bit,
   input wire logic pause_reset_select,
   input wire logic [ADDR_W-1:0] op_addr,
   input wire logic rx_valid,
   input wire logic status_write_refused,
   input wire logic array_write_refused,
   input wire logic [sfe_pkg::SECTOR_W-1:0] sector_index,
   input wire logic [sfe_pkg::HALF_W-1:0] half_block_index,
   input wire logic [sfe_pkg::BLOCK_W-1:0] block_index,
   input wire logic addr_out_of_range,
   input wire logic link_selected,
   input wire logic link_paused,
   input wire logic pin_reset_active
);
   // all checks live in the core clock domain
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   chk_idle_release: assert property (chip_select_n |-> data_line_zero_oe_n && data_line_one_oe_n)
      else $error("line driven while deselected");
   chk_reset_quiet: assert property ($fell(rst) |-> !rx_valid && !link_selected && !status_write_refused)
      else $error("output active right after reset");
   chk_status_lock: assert property (
      (!quad_enable_bit && !data_line_two_in && !status_lock_upper && status_lock_lower)[*6] |-> status_write_refused)
      else $error("locked status write not refused");
   chk_quad_pins: assert property (
      quad_enable_bit[*6] |-> !status_write_refused && !array_write_refused && !pin_reset_active && !link_paused)
      else $error("pin function active with quad enabled");
   chk_pin_reset: assert property (
      (!quad_enable_bit && pause_reset_select && !data_line_three_in)[*6] |-> pin_reset_active)
      else $error("pin reset not seen");
   chk_pause_quiet: assert property (link_paused |-> data_line_one_oe_n && data_line_zero_oe_n)
      else $error("line driven while paused");
   chk_byte_spacing: assert property (rx_valid |=> !rx_valid [*8])
      else $error("received bytes too close");
   chk_sector_map: assert property (
      !$past(rst) && $past(op_addr) <= 24'h1fffff |-> {sector_index, half_block_index, block_index}
      == $past({op_addr[20:12], op_addr[20:15], op_addr[20:16]}))
      else $error("array index wrong");
   chk_range_flag: assert property (!$past(rst) |-> addr_out_of_range == ($past(op_addr) > 24'h1fffff))
      else $error("range flag wrong");
   chk_deselect_clear: assert property (chip_select_n [*8] |-> !link_selected && !link_paused)
      else $error("link state kept after deselect");

   cover property (rx_valid);
   cover property (link_paused);
   cover property (pin_reset_active);
endmodule : sfe_front_end_checker

bind sfe_front_end sfe_front_end_checker #(.ADDR_W(ADDR_W)) u_chk (
   .ref_clk, .rst, .chip_select_n, .data_line_zero_oe_n, .data_line_one_oe_n, .data_line_two_in,
   .data_line_three_in, .status_lock_upper, .status_lock_lower, .quad_enable_bit, .pause_reset_select,
   .op_addr, .rx_valid, .status_write_refused, .array_write_refused, .sector_index, .half_block_index,
   .block_index, .addr_out_of_range, .link_selected, .link_paused, .pin_reset_active);

//--- bench/sfe_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host controller: link clock, select and data lanes
// ---------------------------------------------------------------
module sfe_host_model (
   input wire logic [3:0] line,
   output logic sclk,
   output logic cs_n,
   output logic [3:0] hd,
   output logic [3:0] hoe
);
   logic m3 = 1'b0;       // clock idles high between frames
   logic rd = 1'b0;       // all lanes released for device output
   logic hold_n = 1'b1;   // pause or reset pin level
   logic wp_n = 1'b1;     // protect pin level
   logic [3:0] dd = 4'h0; // lane data
   logic [3:0] de = 4'h1; // lanes used as data
   // lanes 2 and 3 carry the pins unless they move data
   assign hd = {de[3] ? dd[3] : hold_n, de[2] ? dd[2] : wp_n, dd[1:0]};
   assign hoe = rd ? 4'h0 : (de | 4'hc);
   // select wrongly low from power-up; clock stands still
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b0;
   end
   // open a frame at the chosen idle level
   task automatic start(input logic mode3);
      m3 = mode3;
      sclk = mode3;
      #62.5 cs_n = 1'b0;
      #62.5 sclk = 1'b0;
   endtask : start
   // close a frame and stay deselected and idle
   task automatic stop();
      #62.5 sclk = m3;
      #62.5 cs_n = 1'b1;
      #250;
   endtask : stop
   // n lanes, st clock periods, msb first; bits change while clock is low
   task automatic xfer(input logic [7:0] b, input int n, input int st, input logic rdx, output logic [7:0] r);
      logic [7:0] s;
      s = b;
      r = 8'h00;
      rd = rdx;
      de = rdx ? 4'h0 : 4'((1 << n) - 1);
      for (int i = 0; i < st; i++)
      begin
         dd = 4'(s >> (8 - n));
         s = s << n;
         #62.5 sclk = 1'b1;
         r = (r << n) | 8'(n == 1 ? {3'h0, line[1]} : line & 4'((1 << n) - 1));
         #62.5 sclk = 1'b0;
      end
   endtask : xfer
endmodule : sfe_host_model

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ---------------------------------------------------------------
   // stimulus, wires and the front end
   // ---------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic rst = 1'b0;
   logic status_lock_upper = 1'b0;
   logic status_lock_lower = 1'b0;
   logic quad_enable_bit = 1'b0;
   logic pause_reset_select = 1'b0;
   sfe_pkg::sfe_lane_t lane_mode = sfe_pkg::LANE_SINGLE;
   logic drive_phase = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic [23:0] op_addr = 24'h000000;
   logic array_region_protected = 1'b0;
   logic [7:0] rx_data;
   logic rx_valid, tx_ready, status_write_refused, array_write_refused, addr_out_of_range;
   logic link_selected, link_paused, pin_reset_active, sclk, cs_n;
   logic [sfe_pkg::SECTOR_W-1:0] sector_index;
   logic [sfe_pkg::HALF_W-1:0] half_block_index;
   logic [sfe_pkg::BLOCK_W-1:0] block_index;
   logic [3:0] hd, hoe, d_out, d_oen, line;
   logic [7:0] rxq[$];
   logic [23:0] amap[6] = '{24'h000000, 24'h000fff, 24'h001000, 24'h1e7abc, 24'h1fffff, 24'h200000};
   int n_fail = 0;
   int samples_checked = 0;

   always #5 ref_clk = ~ref_clk;
   // device wins, then host; released lanes show pull-ups or a flipped value
   assign line = (~d_oen & d_out) | (d_oen & hoe & hd) | (d_oen & ~hoe & {2'b11, ~hd[1:0]});
   // collect every received byte
   always @(posedge ref_clk)
      if (rx_valid)
         rxq.push_back(rx_data);

   sfe_host_model host (.line(line), .sclk(sclk), .cs_n(cs_n), .hd(hd), .hoe(hoe));
   sfe_front_end #(.ADDR_W(24)) dut (.ref_clk, .rst, .serial_clk(sclk), .chip_select_n(cs_n),
      .data_line_zero_in(line[0]), .data_line_zero_out(d_out[0]), .data_line_zero_oe_n(d_oen[0]),
      .data_line_one_in(line[1]), .data_line_one_out(d_out[1]), .data_line_one_oe_n(d_oen[1]),
      .data_line_two_in(line[2]), .data_line_two_out(d_out[2]), .data_line_two_oe_n(d_oen[2]),
      .data_line_three_in(line[3]), .data_line_three_out(d_out[3]), .data_line_three_oe_n(d_oen[3]),
      .status_lock_upper, .status_lock_lower, .quad_enable_bit, .pause_reset_select, .lane_mode,
      .drive_phase, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready, .op_addr, .array_region_protected,
      .status_write_refused, .array_write_refused, .sector_index, .half_block_index, .block_index,
      .addr_out_of_range, .link_selected, .link_paused, .pin_reset_active);

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic test_done();
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   // next received byte, waited for under a bound
   task automatic rx_chk(input logic [7:0] e);
      for (int k = 0; k < 200 && rxq.size() == 0; k++)
         @(posedge ref_clk);
      if (rxq.size() == 0)
      begin
         n_fail++;
         test_done();
      end
      else
         check(rxq.pop_front(), e);
   endtask : rx_chk
   task automatic cfg(input sfe_pkg::sfe_lane_t l, input logic q, input logic dp);
      @(posedge ref_clk);
      lane_mode <= l;
      quad_enable_bit <= q;
      drive_phase <= dp;
      tick(4);
   endtask : cfg
   // one whole frame holding one byte
   task automatic send(input logic [7:0] b, input int n, input logic m3);
      logic [7:0] r;
      host.start(m3);
      host.xfer(b, n, 8 / n, 1'b0, r);
      host.stop();
   endtask : send

   initial
   begin
      logic [7:0] r;
      logic [31:0] s;
      logic e;
      // a real rising edge, so the async resets see it
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(1);
      // select low since power-up: the byte is dropped
      host.xfer(8'h81, 1, 8, 1'b0, r);
      host.stop();
      tick(20);
      check(24'(rxq.size()), 24'h0);
      host.start(1'b0);
      host.xfer(8'ha5, 1, 8, 1'b0, r);
      host.xfer(8'h3c, 1, 8, 1'b0, r);
      host.stop();
      rx_chk(8'ha5);
      rx_chk(8'h3c);
      send(8'hc3, 1, 1'b1);
      rx_chk(8'hc3);
      cfg(sfe_pkg::LANE_DUAL, 1'b0, 1'b0);
      send(8'h96, 2, 1'b0);
      rx_chk(8'h96);
      cfg(sfe_pkg::LANE_QUAD, 1'b1, 1'b0);
      send(8'h1e, 4, 1'b0);
      rx_chk(8'h1e);
      // reads on 1, 2 and 4 lanes; the byte may start on any clock
      for (int i = 0; i < 3; i++)
      begin
         cfg(sfe_pkg::sfe_lane_t'(i), i == 2, 1'b1);
         tx_data <= 8'h4b;
         tx_valid <= 1'b1;
         tick(1);
         tx_valid <= 1'b0;
         tick(1);
         check(tx_ready, 1'b0);
         host.start(1'b0);
         s = 32'h0;
         for (int k = 0; k < 4; k++)
         begin
            host.xfer(8'h00, 1 << i, 8 >> i, 1'b1, r);
            s = {s[23:0], r};
         end
         host.stop();
         check(tx_ready, 1'b1);
         e = 1'b0;
         for (int j = 0; j < 25; j++)
            e = e | (s[j +: 8] == 8'h4b);
         check(e, 1'b1);
      end
      // early read edges still receive; drop that byte
      rxq.delete();
      cfg(sfe_pkg::LANE_SINGLE, 1'b0, 1'b0);
      // partial byte dropped by deselect, plain and while paused
      for (int p = 0; p < 2; p++)
      begin
         host.start(1'b0);
         host.xfer(8'h00, 1, 5, 1'b0, r);
         host.hold_n = (p == 0);
         #300;
         host.stop();
         host.hold_n = 1'b1;
         send(8'h69, 1, 1'b0);
         rx_chk(8'h69);
      end
      // pause in mid-byte; clocks while paused are ignored
      host.start(1'b0);
      host.xfer(8'hd2, 1, 4, 1'b0, r);
      host.hold_n = 1'b0;
      #300;
      check(link_paused, 1'b1);
      check(link_selected, 1'b1);
      host.xfer(8'hff, 1, 3, 1'b0, r);
      host.hold_n = 1'b1;
      #100;
      host.xfer(8'h20, 1, 4, 1'b0, r);
      host.stop();
      rx_chk(8'hd2);
      // pause pin as reset: the frame is ignored
      @(posedge ref_clk);
      pause_reset_select <= 1'b1;
      host.hold_n = 1'b0;
      send(8'h77, 1, 1'b0);
      check(pin_reset_active, 1'b1);
      host.hold_n = 1'b1;
      tick(20);
      check(24'(rxq.size()), 24'h0);
      // every mix of locks, protect pin, quad enable and region
      for (int c = 0; c < 32; c++)
      begin
         @(posedge ref_clk);
         {array_region_protected, quad_enable_bit, host.wp_n, status_lock_upper, status_lock_lower} <= 5'(c);
         tick(6);
         e = ~c[3] & ~c[2] & ~c[1] & c[0];
         check(status_write_refused, e);
         check(array_write_refused, e & c[4]);
      end
      foreach (amap[j])
      begin
         @(posedge ref_clk);
         op_addr <= amap[j];
         tick(3);
         check(addr_out_of_range, amap[j] > sfe_pkg::TOP_ADDR);
         if (amap[j] <= sfe_pkg::TOP_ADDR)
            check({sector_index, half_block_index, block_index}, {amap[j][20:12], amap[j][20:15], amap[j][20:16]});
      end
      test_done();
   end
endmodule : testbench
